// >>> hw/dcg_ctrl.sv
// Clock gating control for the four clocks that the DSP core distributes.
// Assumes core_idle and wdog_mode come from logic on clk, and that the
// source clocks are derived synchronously from clk.
//
// Contract
// - Idle-select bit 1 stops reference clock in idle
// - Idle-select bit 0 stops watchdog clock in idle
// - Watchdog mode keeps an enabled watchdog clock running in idle; enable bit 0 still gates it
// - Enable bit 5 gates timer clock
// - Enable bit 2 gates peripheral clock
// - Enable bit 1 gates reference clock
// - Enable bit 0 gates watchdog clock
// - Reset clears all enables and idle selects
// - Reserved bits and registers ignore writes
// - Idle-select bit 8 stops timer clock in idle
// - Idle-select bit 2 stops peripheral clock in idle
// - Registers use 16-bit accesses at byte offsets
`timescale 1ns/1ps
module dcg_ctrl
   import dcg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic core_idle,
   input wire logic wdog_mode,
   input wire dcg_req_t req,
   output dcg_rsp_t rsp,
   input wire logic timer_src_clk,
   input wire logic periph_src_clk,
   input wire logic ref_src_clk,
   input wire logic wdog_src_clk,
   output logic core_timer_clock,
   output logic ext_periph_clock,
   output logic ext_reference_clock,
   output logic timer_wdog_clock,
   output logic [3:0] gate_en
);

   logic rst_meta_r;
   logic rst_sync_n;
   logic [15:0] idle_sel_r;
   logic [15:0] clk_en_r;
   logic [3:0] gate_en_r;
   logic [3:0] gate_en_nxt;
   logic rsp_ack_r;
   logic [15:0] rsp_rdata_r;
   logic [15:0] rd_nxt;
   logic wr_is;
   logic wr_en;
   logic [3:0] gate_lat;

   // Clock stays on unless disabled, or idle-stopped and not kept alive
   function automatic logic eff_en(input logic on, input logic stop,
                                   input logic idle, input logic keep);
      eff_en = on && !(idle && stop && !keep);
   endfunction

   // Release of reset is synchronised; assertion stays asynchronous
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_n <= rst_meta_r;
      end
   end

   assign wr_is = req.sel && req.wr && (req.addr == DCG_OFS_IDLE_SEL);
   assign wr_en = req.sel && req.wr && (req.addr == DCG_OFS_CLK_EN);

   // Only the documented fields are stored; bits 4:3 of the enable
   // register are expected to be written as zero and are dropped.
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         idle_sel_r <= DCG_IS_RESET;
         clk_en_r <= DCG_EN_RESET;
      end else if (ce) begin
         if (wr_is) begin
            idle_sel_r <= req.wdata & DCG_IS_MASK;
         end
         if (wr_en) begin
            clk_en_r <= req.wdata & DCG_EN_MASK;
         end
      end
   end

   always_comb begin
      gate_en_nxt[DCG_G_TIMER] = eff_en(clk_en_r[DCG_EN_TIMER],
         idle_sel_r[DCG_IS_TIMER], core_idle, 1'b0);
      gate_en_nxt[DCG_G_PERIPH] = eff_en(clk_en_r[DCG_EN_PERIPH],
         idle_sel_r[DCG_IS_PERIPH], core_idle, 1'b0);
      gate_en_nxt[DCG_G_REF] = eff_en(clk_en_r[DCG_EN_REF],
         idle_sel_r[DCG_IS_REF], core_idle, 1'b0);
      gate_en_nxt[DCG_G_WDOG] = eff_en(clk_en_r[DCG_EN_WDOG],
         idle_sel_r[DCG_IS_WDOG], core_idle, wdog_mode);
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         gate_en_r <= DCG_GATE_RESET;
      end else if (ce) begin
         gate_en_r <= gate_en_nxt;
      end
   end

   assign gate_en = gate_en_r;

   // Reserved registers and unmapped offsets read as zero
   always_comb begin
      case (req.addr)
         DCG_OFS_IDLE_SEL: rd_nxt = idle_sel_r;
         DCG_OFS_CLK_EN: rd_nxt = clk_en_r;
         default: rd_nxt = 16'h0000;
      endcase
   end

   // Every access made while ce is high is answered one cycle later, reads with data
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rsp_ack_r <= 1'b0;
         rsp_rdata_r <= 16'h0000;
      end else if (ce) begin
         rsp_ack_r <= req.sel;
         if (req.sel && !req.wr) begin
            rsp_rdata_r <= rd_nxt;
         end
      end
   end

   assign rsp.ack = rsp_ack_r;
   assign rsp.rdata = rsp_rdata_r;

   // Enable is taken only while the source clock is low, so a change
   // never truncates a high phase. Enables held during reset stay off.
   always_latch begin
      if (!timer_src_clk) gate_lat[DCG_G_TIMER] = gate_en_r[DCG_G_TIMER];
   end
   always_latch begin
      if (!periph_src_clk) gate_lat[DCG_G_PERIPH] = gate_en_r[DCG_G_PERIPH];
   end
   always_latch begin
      if (!ref_src_clk) gate_lat[DCG_G_REF] = gate_en_r[DCG_G_REF];
   end
   always_latch begin
      if (!wdog_src_clk) gate_lat[DCG_G_WDOG] = gate_en_r[DCG_G_WDOG];
   end

   assign core_timer_clock = timer_src_clk & gate_lat[DCG_G_TIMER];
   assign ext_periph_clock = periph_src_clk & gate_lat[DCG_G_PERIPH];
   assign ext_reference_clock = ref_src_clk & gate_lat[DCG_G_REF];
   assign timer_wdog_clock = wdog_src_clk & gate_lat[DCG_G_WDOG];

   a_reset_clear: assert property (@(posedge clk)
      $rose(rst_sync_n) |-> idle_sel_r == 16'h0000 && clk_en_r == 16'h0000
         && gate_en_r == 4'h0)
      else $error("state not cleared by reset");

   a_wdog_kept: assert property (@(posedge clk) disable iff (!rst_sync_n)
      ce && wdog_mode && clk_en_r[0] |=> gate_en_r[3])
      else $error("watchdog clock stopped in watchdog mode");

   a_wdog_idle_stop: assert property (@(posedge clk) disable iff (!rst_sync_n)
      ce && core_idle && !wdog_mode && idle_sel_r[0] |=> !gate_en_r[3])
      else $error("watchdog clock ran in idle");

   a_ref_idle_run: assert property (@(posedge clk) disable iff (!rst_sync_n)
      ce && clk_en_r[1] && !idle_sel_r[1] |=> gate_en_r[2])
      else $error("reference clock stopped though not idle-selected");

   a_timer_idle: assert property (@(posedge clk) disable iff (!rst_sync_n)
      ce && clk_en_r[5] && idle_sel_r[8] |=> gate_en_r[0] == !$past(core_idle))
      else $error("timer clock idle behaviour wrong");

   a_periph_off: assert property (@(posedge clk) disable iff (!rst_sync_n)
      ce && !clk_en_r[2] |=> !gate_en_r[1])
      else $error("peripheral clock running while disabled");

   a_periph_idle: assert property (@(posedge clk) disable iff (!rst_sync_n)
      ce && clk_en_r[2] && !idle_sel_r[2] && core_idle |=> gate_en_r[1])
      else $error("peripheral clock stopped though not idle-selected");

   a_en_write: assert property (@(posedge clk) disable iff (!rst_sync_n)
      ce && wr_en && req.wdata[1] && !core_idle ##1 ce && !wr_en && !core_idle
         |=> gate_en_r[2])
      else $error("reference clock not enabled after write");

   a_rsvd_write: assert property (@(posedge clk) disable iff (!rst_sync_n)
      req.sel && req.wr && (req.addr == 8'h0c || req.addr == 8'h10)
         |=> $stable(idle_sel_r) && $stable(clk_en_r))
      else $error("reserved register write changed state");

   a_read_ack: assert property (@(posedge clk) disable iff (!rst_sync_n)
      ce && req.sel && !req.wr && req.addr == 8'h08 && !wr_en
         |=> rsp.ack && rsp.rdata == $past(clk_en_r) && rsp.rdata[15:6] == 10'h0)
      else $error("enable register read answered wrongly");

   // Gate checks hold for sources no slower than half the control clock
   a_gate_low: assert property (@(posedge clk) disable iff (!rst_sync_n)
      !gate_en_r[DCG_G_TIMER] && !$past(gate_en_r[DCG_G_TIMER])
         |-> !core_timer_clock)
      else $error("timer clock output high while gated");

   a_gate_low_per: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      !gate_en_r[DCG_G_PERIPH] && !$past(gate_en_r[DCG_G_PERIPH])
         |-> !ext_periph_clock)
      else $error("peripheral clock output high while gated");

   a_gate_low_ref: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      !gate_en_r[DCG_G_REF] && !$past(gate_en_r[DCG_G_REF])
         |-> !ext_reference_clock)
      else $error("reference clock output high while gated");

   a_gate_low_wdg: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      !gate_en_r[DCG_G_WDOG] && !$past(gate_en_r[DCG_G_WDOG])
         |-> !timer_wdog_clock)
      else $error("watchdog clock output high while gated");

   a_timer_off: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && !clk_en_r[DCG_EN_TIMER] |=> !gate_en_r[DCG_G_TIMER])
      else $error("timer clock running while disabled");

   a_timer_on: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && clk_en_r[DCG_EN_TIMER] && !core_idle |=> gate_en_r[DCG_G_TIMER])
      else $error("timer clock stopped while enabled");

   a_periph_on: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && clk_en_r[DCG_EN_PERIPH] && !core_idle
         |=> gate_en_r[DCG_G_PERIPH])
      else $error("peripheral clock stopped while enabled");

   a_ref_off: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && !clk_en_r[DCG_EN_REF] |=> !gate_en_r[DCG_G_REF])
      else $error("reference clock running while disabled");

   a_ref_on: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && clk_en_r[DCG_EN_REF] && !core_idle |=> gate_en_r[DCG_G_REF])
      else $error("reference clock stopped while enabled");

   a_wdog_off: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && !clk_en_r[DCG_EN_WDOG] |=> !gate_en_r[DCG_G_WDOG])
      else $error("watchdog clock running while disabled");

   a_wdog_on: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && clk_en_r[DCG_EN_WDOG] && !core_idle |=> gate_en_r[DCG_G_WDOG])
      else $error("watchdog clock stopped while enabled");

   a_ref_idle_stop: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && core_idle && idle_sel_r[DCG_IS_REF] |=> !gate_en_r[DCG_G_REF])
      else $error("reference clock ran in idle");

   a_per_idle_stop: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && core_idle && idle_sel_r[DCG_IS_PERIPH]
         |=> !gate_en_r[DCG_G_PERIPH])
      else $error("peripheral clock ran in idle");

   a_timer_idle_run: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && clk_en_r[DCG_EN_TIMER] && !idle_sel_r[DCG_IS_TIMER]
         |=> gate_en_r[DCG_G_TIMER])
      else $error("timer clock stopped though not idle-selected");

   a_wdog_idle_run: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && clk_en_r[DCG_EN_WDOG] && !idle_sel_r[DCG_IS_WDOG]
         |=> gate_en_r[DCG_G_WDOG])
      else $error("watchdog clock stopped though not idle-selected");

   a_is_mask: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      (idle_sel_r & ~DCG_IS_MASK) == 16'h0000)
      else $error("reserved idle-select bit stored");

   a_en_mask: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      (clk_en_r & ~DCG_EN_MASK) == 16'h0000)
      else $error("reserved enable bit stored");

   a_freeze_regs: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      !ce |=> $stable(idle_sel_r) && $stable(clk_en_r) && $stable(gate_en_r))
      else $error("register changed while clock enable low");

   a_freeze_rsp: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      !ce |=> $stable(rsp.ack) && $stable(rsp.rdata))
      else $error("response changed while clock enable low");

   a_ack_idle: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && !req.sel |=> !rsp.ack)
      else $error("acknowledge without request");

   a_rdata_hold: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && !(req.sel && !req.wr) |=> $stable(rsp.rdata))
      else $error("read data changed without a read");

   a_read_is: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && req.sel && !req.wr && req.addr == DCG_OFS_IDLE_SEL
         |=> rsp.ack && rsp.rdata == $past(idle_sel_r))
      else $error("idle-select register read answered wrongly");

   a_rsvd_read: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && req.sel && !req.wr
         && (req.addr == DCG_OFS_RSVD_A || req.addr == DCG_OFS_RSVD_B)
         |=> rsp.rdata == 16'h0000)
      else $error("reserved register read not zero");

   a_other_write: assert property (@(posedge clk)
      disable iff (!rst_sync_n)
      ce && req.sel && req.wr && req.addr != DCG_OFS_CLK_EN
         |=> $stable(clk_en_r))
      else $error("enable register changed by another write");

   a_reset_hold: assert property (@(posedge clk)
      !rst_sync_n |-> gate_en_r == DCG_GATE_RESET && !rsp.ack)
      else $error("state not held cleared in reset");

endmodule // dcg_ctrl

// >>> hw/dcg_pkg.sv
// Constants, register map and carrier types for the DSP clock gating block.
// Assumes a 16-bit register port clocked by the control clock.
package dcg_pkg;
   // Byte offsets of the register map
   localparam logic [7:0] DCG_OFS_IDLE_SEL = 8'h04;
   localparam logic [7:0] DCG_OFS_CLK_EN = 8'h08;
   localparam logic [7:0] DCG_OFS_RSVD_A = 8'h0c;
   localparam logic [7:0] DCG_OFS_RSVD_B = 8'h10;

   // Idle-select register field positions
   localparam int DCG_IS_WDOG = 0;
   localparam int DCG_IS_REF = 1;
   localparam int DCG_IS_PERIPH = 2;
   localparam int DCG_IS_TIMER = 8;

   // Clock-enable register field positions
   localparam int DCG_EN_WDOG = 0;
   localparam int DCG_EN_REF = 1;
   localparam int DCG_EN_PERIPH = 2;
   localparam int DCG_EN_TIMER = 5;

   // Writable bits of each register
   localparam logic [15:0] DCG_IS_MASK = 16'h0107;
   localparam logic [15:0] DCG_EN_MASK = 16'h0027;

   // Values after reset
   localparam logic [15:0] DCG_IS_RESET = 16'h0000;
   localparam logic [15:0] DCG_EN_RESET = 16'h0000;
   localparam logic [3:0] DCG_GATE_RESET = 4'h0;

   // Index of each gated clock in the gate vector
   localparam int DCG_G_TIMER = 0;
   localparam int DCG_G_PERIPH = 1;
   localparam int DCG_G_REF = 2;
   localparam int DCG_G_WDOG = 3;

   typedef struct packed {
      logic sel;
      logic wr;
      logic [7:0] addr;
      logic [15:0] wdata;
   } dcg_req_t;

   typedef struct packed {
      logic ack;
      logic [15:0] rdata;
   } dcg_rsp_t;
endpackage

// >>> test/tb.sv
// Self-checking bench for the DSP clock gating control block.
// Assumes one 40 MHz clock; all source clocks come from one divided clock.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
   n_compared++; \
   if ((got) !== (ex)) begin \
      n_fail++; \
      $display("wrong value %s exp %h got %h", nm, ex, got); \
   end \
end
module tb;
   import dcg_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic core_idle = 1'b0;
   logic wdog_mode = 1'b0;
   logic sclk = 1'b0;
   dcg_req_t req = '0;
   dcg_rsp_t rsp;
   logic ct, cp, cr, cw;
   logic [3:0] gate_en;
   int n_fail = 0;
   int n_compared = 0;
   logic [15:0] rd, is_v, en_v;
   logic [7:0] ra;

   dcg_ctrl u_dcg_ctrl (.clk(clk), .rst_n(rst_n), .ce(ce),
      .core_idle(core_idle), .wdog_mode(wdog_mode), .req(req), .rsp(rsp),
      .timer_src_clk(sclk), .periph_src_clk(sclk), .ref_src_clk(sclk),
      .wdog_src_clk(sclk), .core_timer_clock(ct), .ext_periph_clock(cp),
      .ext_reference_clock(cr), .timer_wdog_clock(cw), .gate_en(gate_en));

   initial begin
      forever #12.5 clk = ~clk;
   end
   // Source clock at half rate, edges aligned to clk
   always @(posedge clk) sclk <= ~sclk;

   function automatic logic [3:0] exp_gate(input logic [15:0] is,
         input logic [15:0] en, input logic idl, input logic wd);
      exp_gate[0] = en[5] & ~(idl & is[8]);
      exp_gate[1] = en[2] & ~(idl & is[2]);
      exp_gate[2] = en[1] & ~(idl & is[1]);
      // Watchdog mode only overrides the idle stop
      exp_gate[3] = en[0] & ~(idl & is[0] & ~wd);
   endfunction

   task automatic tally_and_finish;
      if (n_fail == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic access(input logic wr, input logic [7:0] a,
         input logic [15:0] d);
      @(posedge clk);
      req <= '{sel: 1'b1, wr: wr, addr: a, wdata: d};
      @(posedge clk);
      req.sel <= 1'b0;
      #1;
      `CHK("ack", 1'b1, rsp.ack)
      rd = rsp.rdata;
   endtask

   // Gate vector two edges after the cause, clock pins in a high phase
   task automatic check_gates(input logic [3:0] ex);
      @(posedge clk);
      @(posedge clk);
      #1;
      `CHK("gate_en", ex, gate_en)
      @(posedge sclk);
      #1;
      `CHK("clocks", ex, {cw, cr, cp, ct})
   endtask

   initial begin
      void'($urandom(68202));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      `CHK("gate_en rst", 4'h0, gate_en)
      access(1'b0, DCG_OFS_IDLE_SEL, 16'h0000);
      `CHK("idle sel rst", 16'h0000, rd)
      access(1'b0, DCG_OFS_CLK_EN, 16'h0000);
      `CHK("clk en rst", 16'h0000, rd)
      for (int i = 0; i < 150; i++) begin
         is_v = (i < 2) ? 16'hffff : 16'($urandom);
         en_v = ((i < 2) ? 16'hffff : 16'($urandom)) & 16'hffe7;
         access(1'b1, DCG_OFS_IDLE_SEL, is_v);
         access(1'b1, DCG_OFS_CLK_EN, en_v);
         ra = ($urandom % 2) ? DCG_OFS_RSVD_A : DCG_OFS_RSVD_B;
         access(1'b1, ra, 16'($urandom));
         @(posedge clk);
         core_idle <= (i < 2) ? 1'b1 : 1'($urandom);
         wdog_mode <= (i < 2) ? i[0] : 1'($urandom);
         @(posedge clk);
         check_gates(exp_gate(is_v, en_v, core_idle, wdog_mode));
         // Write with ce low must be neither stored nor answered
         @(posedge clk);
         ce <= 1'b0;
         req <= '{sel: 1'b1, wr: 1'b1, addr: DCG_OFS_CLK_EN,
            wdata: ~en_v & 16'hffe7};
         @(posedge clk);
         req.sel <= 1'b0;
         #1;
         `CHK("frozen ack", 1'b0, rsp.ack)
         @(posedge clk);
         ce <= 1'b1;
         access(1'b0, DCG_OFS_IDLE_SEL, 16'h0000);
         `CHK("idle sel", is_v & 16'h0107, rd)
         access(1'b0, DCG_OFS_CLK_EN, 16'h0000);
         `CHK("clk en", en_v & 16'h0027, rd)
         access(1'b0, ra, 16'h0000);
         `CHK("reserved", 16'h0000, rd)
         access(1'b0, 8'h80 | 8'($urandom), 16'h0000);
         `CHK("unmapped", 16'h0000, rd)
      end
      tally_and_finish();
   end

   // Loop needs about 3400 cycles
   initial begin
      #(25 * 20000);
      n_fail++;
      tally_and_finish();
   end
endmodule // tb
